// ==== asc_pkg.sv ====
// Notes on behaviour
// - Conversion clock comes from system clock when source bit is 0, RC tick when 1.
// - System-clock conversion period is system period times divider plus one.
// - Divider above 63 is reserved; flagged as error and conversions held off.
// - Result format: 00 unsigned, 01 signed, 10 unsigned fraction, 11 signed fraction.
// - Sampling of active channels restarts automatically once the sweep completes.
// - Cleared auto-sample bit is an error; no conversion is started.
// - Trigger select: 001 external, 010/100 timer, 011/101 PWM event.
// - One conversion lasts 12 conversion clocks in 10-bit, 14 in 12-bit mode.
// - 12-bit mode converts only the primary channel, others ignored.
// - 10-bit channel count: 00 one, 01 two, 1x four channels.
// - Simultaneous mode: trigger ends sampling on all active channels at once.
// - Sequential mode: trigger ends primary sampling; each next ends on previous done.
// - Triggers while converting are dropped; start only while all active sample.
// - Interrupt after N, 2N or 4N conversions with count field N-1; code scales N by channel count only in simultaneous mode.
// - Each result goes to next of 16 buffer words; over 16 is flagged.
// - Primary positive input from 5-bit select; negative is reference or input 1.
// - Group positive 0-2 or 3-5; group negative 6-8, 9-11 or reference.
// - Alternate bit clear: only first multiplexer settings are used.
// - Alternate bit set: first and second settings swap every sweep.
// - Scan enabled: primary steps through marked inputs in ascending order.
// - Scan plus alternate: primary alternates next scanned input and second mux input.
package asc_pkg;

   localparam logic [7:0] OFS_CTL1    = 8'h00;
   localparam logic [7:0] OFS_CTL2    = 8'h04;
   localparam logic [7:0] OFS_CTL3    = 8'h08;
   localparam logic [7:0] OFS_PRI     = 8'h0c;
   localparam logic [7:0] OFS_GRP     = 8'h10;
   localparam logic [7:0] OFS_SCAN    = 8'h14;
   localparam logic [7:0] OFS_STAT    = 8'h18;
   localparam logic [7:0] OFS_BUF     = 8'h40;
   localparam logic [7:0] DIV_MAX     = 8'h3f;
   localparam logic [3:0] LEN10_M1    = 4'hb;
   localparam logic [3:0] LEN12_M1    = 4'hd;
   localparam logic [6:0] BUF_WORDS   = 7'h10;

   localparam logic [2:0] TRG_EXT     = 3'h1;
   localparam logic [2:0] TRG_TMR_A   = 3'h2;
   localparam logic [2:0] TRG_PWM_A   = 3'h3;
   localparam logic [2:0] TRG_TMR_B   = 3'h4;
   localparam logic [2:0] TRG_PWM_B   = 3'h5;

   localparam logic [1:0] FMT_UINT    = 2'h0;
   localparam logic [1:0] FMT_SINT    = 2'h1;
   localparam logic [1:0] FMT_UFRAC   = 2'h2;

   typedef enum logic {ST_SAMPLE, ST_CONV} asc_state_t;

   typedef struct packed {
      logic       mode12;
      logic [1:0] fmt;
      logic [2:0] trig;
      logic       auto_s;
   } asc_ctl1_t;

   typedef struct packed {
      logic       scan_en;
      logic       alternate_input_sel;
      logic [3:0] conversions_per_irq;
      logic       simultaneous_sample_sel;
      logic [1:0] active_channel_count;
   } asc_ctl2_t;

   typedef struct packed {
      logic       src;
      logic [7:0] div;
   } asc_ctl3_t;

   typedef struct packed {
      logic       neg_b;
      logic [4:0] pos_b;
      logic       neg_a;
      logic [4:0] pos_a;
   } asc_pri_t;

   typedef struct packed {
      logic [1:0] neg_b;
      logic       pos_b;
      logic [1:0] neg_a;
      logic       pos_a;
   } asc_grp_t;

   typedef struct packed {
      logic       cnt_err;
      logic       auto_err;
      logic       div_err;
      logic       busy;
      logic       use_b;
      logic [3:0] buf_ptr;
   } asc_stat_t;

   typedef struct packed {
      logic [3:0][4:0] pos;
      logic [3:0]      neg_ref;
      logic [3:0][4:0] neg;
   } asc_mux_t;

   typedef struct packed {
      asc_ctl1_t        ctl1;
      asc_ctl2_t        ctl2;
      asc_ctl3_t        ctl3;
      asc_pri_t         pri;
      asc_grp_t         grp;
      logic [31:0]      scan;
      asc_state_t       st;
      logic             busy;
      logic [3:0]       sampling;
      logic [1:0]       chan;
      logic [3:0]       tad_cnt;
      logic [5:0]       div_cnt;
      logic             use_b;
      logic [4:0]       scan_ptr;
      logic [3:0]       buf_ptr;
      logic [6:0]       conv_cnt;
      logic [15:0][15:0] rbuf;
      asc_mux_t         mux;
      logic             irq;
      logic             wait_r;
      logic [31:0]      rdata;
   } asc_regs_t;

   localparam asc_ctl1_t CTL1_RST = '{mode12: 1'b0, fmt: 2'h0, trig: 3'h0, auto_s: 1'b1};

   localparam asc_regs_t REGS_RST = '{
      ctl1: CTL1_RST, st: ST_SAMPLE, sampling: 4'h1, wait_r: 1'b1,
      ctl2: '0, ctl3: '0, pri: '0, grp: '0, scan: '0, busy: 1'b0, chan: 2'h0,
      tad_cnt: 4'h0, div_cnt: 6'h0, use_b: 1'b0, scan_ptr: 5'h0, buf_ptr: 4'h0,
      conv_cnt: 7'h0, rbuf: '0, mux: '0, irq: 1'b0, rdata: 32'h0};

endpackage : asc_pkg

// ==== asc_top.sv ====
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module asc_top
   import asc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        RC_TICK,
   input  wire logic        TRIG_EXT,
   input  wire logic        TRIG_TMR,
   input  wire logic        TRIG_PWM,
   input  wire logic [11:0] CONV_DATA,
   output logic      [3:0]  SAMPLING,
   output logic             CONVERTING,
   output logic      [1:0]  CONV_CHAN,
   output asc_mux_t         MUX_SEL,
   output logic             CONV_IRQ
);

   asc_regs_t   q;
   asc_regs_t   n;
   logic [2:0]  nch;
   logic [1:0]  last_chan;
   logic [3:0]  active;
   logic        div_err;
   logic        auto_err;
   logic        cnt_err;
   logic        cfg_ok;
   logic        trig_hit;
   logic        tick;
   logic [3:0]  len_m1;
   logic [2:0]  mult;
   logic [6:0]  target;
   logic [4:0]  pick;
   logic        done_now;
   logic        sweep_end;
   logic        start;
   logic [31:0] rd_val;
   logic [31:0] wr_full;
   asc_stat_t   stat;

   function automatic logic [4:0] scan_pick(input logic [31:0] m, input logic [4:0] s);
      logic [4:0] k;
      scan_pick = s;
      for (int i = 31; i >= 0; i--) begin
         k = s + 5'(i);
         if (m[k]) begin
            scan_pick = k;
         end
      end
   endfunction : scan_pick

   function automatic logic [15:0] fmt_res(input logic [11:0] r, input logic m12,
                                          input logic [1:0] f);
      logic [11:0] v;
      logic        sgn;
      v   = m12 ? r : {2'h0, r[9:0]};
      sgn = m12 ? ~r[11] : ~r[9];
      if (f == FMT_UINT) begin
         fmt_res = {4'h0, v};
      end else if (f == FMT_SINT) begin
         fmt_res = m12 ? {{5{sgn}}, r[10:0]} : {{7{sgn}}, r[8:0]};
      end else if (f == FMT_UFRAC) begin
         fmt_res = m12 ? {r, 4'h0} : {r[9:0], 6'h0};
      end else begin
         fmt_res = m12 ? {sgn, r[10:0], 4'h0} : {sgn, r[8:0], 6'h0};
      end
   endfunction : fmt_res

   function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
                                           input logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         be_merge[b*8 +: 8] = be[b] ? w[b*8 +: 8] : o[b*8 +: 8];
      end
   endfunction : be_merge

   // 12-bit mode forces a single channel regardless of the count field
   assign nch = q.ctl1.mode12 ? 3'h1 :
                (q.ctl2.active_channel_count == 2'h0) ? 3'h1 : (q.ctl2.active_channel_count == 2'h1) ? 3'h2 : 3'h4;
   assign last_chan = 2'(nch - 3'h1);
   assign active    = (nch == 3'h1) ? 4'h1 : (nch == 3'h2) ? 4'h3 : 4'hf;
   assign div_err   = q.ctl3.div > DIV_MAX;
   assign auto_err  = !q.ctl1.auto_s;
   assign mult      = (q.ctl2.simultaneous_sample_sel && !q.ctl1.mode12) ? nch : 3'h1;
   assign target    = 7'(({3'h0, q.ctl2.conversions_per_irq} + 7'h1) * {4'h0, mult});
   assign cnt_err   = target > BUF_WORDS;
   assign cfg_ok    = !div_err && !auto_err;
   assign len_m1    = q.ctl1.mode12 ? LEN12_M1 : LEN10_M1;
   assign pick      = scan_pick(q.scan, q.scan_ptr);

   always_comb begin
      case (q.ctl1.trig)
         TRG_EXT:              trig_hit = TRIG_EXT;
         TRG_TMR_A, TRG_TMR_B: trig_hit = TRIG_TMR;
         TRG_PWM_A, TRG_PWM_B: trig_hit = TRIG_PWM;
         default:              trig_hit = 1'b0;
      endcase
   end

   // Divider restarts on each tick so the ratio is divider plus one
   assign tick = q.ctl3.src ? RC_TICK : (q.div_cnt == q.ctl3.div[5:0]);

   assign done_now  = (q.st == ST_CONV) && tick && (q.tad_cnt == len_m1);
   assign sweep_end = done_now && (q.chan == last_chan);
   // Trigger honoured only in the sampling state, dropped while converting
   assign start     = (q.st == ST_SAMPLE) && trig_hit && cfg_ok;

   assign stat = '{cnt_err: cnt_err, auto_err: auto_err, div_err: div_err,
                   busy: q.busy, use_b: q.use_b, buf_ptr: q.buf_ptr};

   always_comb begin
      if (AVS_ADDRESS == OFS_CTL1) begin
         rd_val = 32'(q.ctl1);
      end else if (AVS_ADDRESS == OFS_CTL2) begin
         rd_val = 32'(q.ctl2);
      end else if (AVS_ADDRESS == OFS_CTL3) begin
         rd_val = 32'(q.ctl3);
      end else if (AVS_ADDRESS == OFS_PRI) begin
         rd_val = 32'(q.pri);
      end else if (AVS_ADDRESS == OFS_GRP) begin
         rd_val = 32'(q.grp);
      end else if (AVS_ADDRESS == OFS_SCAN) begin
         rd_val = q.scan;
      end else if (AVS_ADDRESS == OFS_STAT) begin
         rd_val = 32'(stat);
      end else if (AVS_ADDRESS[7:6] == OFS_BUF[7:6] && AVS_ADDRESS[1:0] == 2'h0) begin
         rd_val = {16'h0, q.rbuf[AVS_ADDRESS[5:2]]};
      end else begin
         rd_val = 32'h0;
      end
   end

   assign wr_full = be_merge(rd_val, AVS_WRITEDATA, AVS_BYTEENABLE);

   always_comb begin
      n        = q;
      n.irq    = 1'b0;
      n.wait_r = 1'b1;

      // Answer one cycle after the request; write lands when waitrequest is seen low
      if (!q.wait_r) begin
         if (AVS_WRITE) begin
            if (AVS_ADDRESS == OFS_CTL1) begin
               n.ctl1 = asc_ctl1_t'(wr_full[$bits(asc_ctl1_t)-1:0]);
            end else if (AVS_ADDRESS == OFS_CTL2) begin
               n.ctl2 = asc_ctl2_t'(wr_full[$bits(asc_ctl2_t)-1:0]);
            end else if (AVS_ADDRESS == OFS_CTL3) begin
               n.ctl3 = asc_ctl3_t'(wr_full[$bits(asc_ctl3_t)-1:0]);
            end else if (AVS_ADDRESS == OFS_PRI) begin
               n.pri = asc_pri_t'(wr_full[$bits(asc_pri_t)-1:0]);
            end else if (AVS_ADDRESS == OFS_GRP) begin
               n.grp = asc_grp_t'(wr_full[$bits(asc_grp_t)-1:0]);
            end else if (AVS_ADDRESS == OFS_SCAN) begin
               n.scan = wr_full;
            end
         end
      end else if (AVS_READ || AVS_WRITE) begin
         n.wait_r = 1'b0;
         n.rdata  = rd_val;
      end

      n.div_cnt = tick ? 6'h0 : q.div_cnt + 6'h1;

      case (q.st)
         ST_SAMPLE: begin
            if (start) begin
               n.st      = ST_CONV;
               n.chan    = 2'h0;
               n.tad_cnt = 4'h0;
               // Simultaneous freezes every channel, sequential only the primary
               n.sampling = q.ctl2.simultaneous_sample_sel ? 4'h0 : (active & 4'he);
            end else begin
               // Follow channel count changes so all active channels sample
               n.sampling = active;
            end
         end
         ST_CONV: begin
            if (tick) begin
               n.tad_cnt = q.tad_cnt + 4'h1;
               if (done_now) begin
                  n.tad_cnt = 4'h0;
                  n.rbuf[q.buf_ptr] = fmt_res(CONV_DATA, q.ctl1.mode12, q.ctl1.fmt);
                  n.buf_ptr  = q.buf_ptr + 4'h1;
                  n.conv_cnt = q.conv_cnt + 7'h1;
                  if (q.conv_cnt + 7'h1 >= target) begin
                     n.irq      = 1'b1;
                     n.conv_cnt = 7'h0;
                     n.buf_ptr  = 4'h0;
                  end
                  if (sweep_end) begin
                     n.st       = ST_SAMPLE;
                     n.sampling = active;
                     n.use_b    = q.ctl2.alternate_input_sel ? !q.use_b : 1'b0;
                     if (q.ctl2.scan_en && !q.use_b) begin
                        n.scan_ptr = pick + 5'h1;
                     end
                  end else begin
                     n.chan = q.chan + 2'h1;
                     if (!q.ctl2.simultaneous_sample_sel) begin
                        n.sampling = q.sampling & ~(4'h1 << (q.chan + 2'h1));
                     end
                  end
               end
            end
         end
         default: n.st = ST_SAMPLE;
      endcase
      n.busy = (n.st == ST_CONV);

      // Scan overrides the first primary positive select only
      if (q.ctl2.scan_en && !q.use_b) begin
         n.mux.pos[0] = pick;
      end else begin
         n.mux.pos[0] = q.use_b ? q.pri.pos_b : q.pri.pos_a;
      end
      n.mux.neg_ref[0] = q.use_b ? !q.pri.neg_b : !q.pri.neg_a;
      n.mux.neg[0]     = {4'h0, (q.use_b ? q.pri.neg_b : q.pri.neg_a)};
      for (int c = 1; c < 4; c++) begin
         n.mux.pos[c] = 5'(c - 1) + ((q.use_b ? q.grp.pos_b : q.grp.pos_a) ? 5'h3 : 5'h0);
         n.mux.neg_ref[c] = q.use_b ? q.grp.neg_b[1] : q.grp.neg_a[1];
         n.mux.neg[c] = 5'(c + 5) + ((q.use_b ? q.grp.neg_b[0] : q.grp.neg_a[0]) ? 5'h3 : 5'h0);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         q <= REGS_RST;
      end else begin
         q <= n;
      end
   end

   assign AVS_READDATA    = q.rdata;
   assign AVS_WAITREQUEST = q.wait_r;
   assign SAMPLING        = q.sampling;
   assign CONVERTING      = q.busy;
   assign CONV_CHAN       = q.chan;
   assign MUX_SEL         = q.mux;
   assign CONV_IRQ        = q.irq;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   AST_DIV_HOLD: assert property ((q.st == ST_SAMPLE && div_err) |=> q.st == ST_SAMPLE)
      else $error("Conversion started with reserved divider");
   AST_AUTO_HOLD: assert property ((q.st == ST_SAMPLE && auto_err) |=> q.st == ST_SAMPLE)
      else $error("Conversion started without auto-sample");
   AST_TRIG_DROP: assert property ((q.st == ST_CONV && !done_now) |=> (q.st == ST_CONV && $stable(q.chan)))
      else $error("Trigger disturbed a running conversion");
   AST_SIM_STOP: assert property ((start && q.ctl2.simultaneous_sample_sel) |=> (q.sampling == 4'h0 && q.busy))
      else $error("Simultaneous trigger left a channel sampling");
   AST_SEQ_STOP: assert property ((start && !q.ctl2.simultaneous_sample_sel) |=> (!q.sampling[0] && q.sampling[3:1] == $past(active[3:1])))
      else $error("Sequential trigger stopped wrong channels");
   AST_ONE_CH12: assert property ((sweep_end && q.ctl1.mode12) |=> (q.sampling == 4'h1 && q.chan == 2'h0))
      else $error("12-bit sweep used more than one channel");
   AST_CONV_LEN: assert property ((start && !q.ctl1.mode12 && tick && q.ctl3.src == 1'b0 && q.ctl3.div == 8'h0 && $stable(q.ctl3)) |=> (q.tad_cnt == 4'h0) ##11 done_now)
      else $error("10-bit conversion length wrong at full rate");
   AST_IRQ_PTR: assert property (CONV_IRQ |-> (q.buf_ptr == 4'h0 && q.conv_cnt == 7'h0))
      else $error("Buffer position not rewound after interrupt");
   AST_ALT_FLIP: assert property ((sweep_end && q.ctl2.alternate_input_sel) |=> q.use_b != $past(q.use_b))
      else $error("Alternate selection did not flip");
   AST_BUS_ANS: assert property (((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("Bus answer not one cycle wide");

endmodule : asc_top
`default_nettype wire

// ==== asc_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_far_model
   import asc_pkg::*;
#(
   parameter int RC_DIV = 5
)
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [2:0]  fire,
   input  wire logic [6:0]  base,
   input  wire asc_mux_t    mux_sel,
   input  wire logic        converting,
   input  wire logic [1:0]  conv_chan,
   output logic      [2:0]  trig,
   output logic             rc_tick,
   output logic      [11:0] conv_data
);
   int          rc_cnt;
   logic [11:0] val;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig    <= 3'h0;
         rc_cnt  <= 0;
         rc_tick <= 1'b0;
      end else begin
         trig    <= fire;
         rc_cnt  <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
         rc_tick <= (rc_cnt == RC_DIV - 1);
      end
   end

   // Value tags the selected input; not held once conversion ends
   assign val       = {base, mux_sel.pos[conv_chan]};
   assign conv_data = converting ? val : ~val;
endmodule : asc_far_model
`default_nettype wire

// ==== asc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_top_tb;
   import asc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q, rdat;
   logic [2:0]  fire = 3'h0;
   logic [2:0]  trig;
   logic [6:0]  base = 7'h00;
   logic [15:0] lf = 16'h6cfa;
   logic        wreq, conv, irq, tick;
   logic [3:0]  samp, s1;
   logic [1:0]  chan;
   logic [11:0] cdat;
   asc_mux_t    mux;
   int          mismatches = 0;
   int          tests_run = 0;
   int          irqs = 0;
   int          len;

   always #12.5 clk = ~clk;
   always @(negedge clk) if (irq === 1'b1) irqs++;

   asc_top u_dut (.SYS_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .RC_TICK(tick), .TRIG_EXT(trig[0]), .TRIG_TMR(trig[1]),
      .TRIG_PWM(trig[2]), .CONV_DATA(cdat), .SAMPLING(samp), .CONVERTING(conv),
      .CONV_CHAN(chan), .MUX_SEL(mux), .CONV_IRQ(irq));
   asc_far_model u_far (.clk(clk), .rst_b(rst_b), .fire(fire), .base(base), .mux_sel(mux),
      .converting(conv), .conv_chan(chan), .trig(trig), .rc_tick(tick), .conv_data(cdat));

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", w, e, g);
      end
   endtask : chk

   // Reference result: raw value tags the input, then formatted
   function automatic logic [15:0] fmt(input int p, input logic [31:0] c);
      int w, v;
      w = c[6] ? 12 : 10;
      v = ((int'(base) << 5) | p) % (1 << w);
      if (c[4]) v = v ^ (1 << (w - 1));
      if (c[4] && !c[5] && v >= (1 << (w - 1))) v = v - (1 << w);
      if (c[5]) v = v << (16 - w);
      return v[15:0];
   endfunction : fmt

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat;
      if (n >= 40) mismatches++;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rst;
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask : rst

   task automatic conv_run(input logic [2:0] f, input bit again);
      int n;
      fire <= f;
      @(posedge clk);
      fire <= 3'h0;
      len = 0;
      n = 0;
      while (conv !== 1'b1 && n < 8) begin
         @(posedge clk);
         n++;
      end
      s1 = samp;
      while (conv === 1'b1 && len < 3000) begin
         @(posedge clk);
         len++;
         // Retrigger mid-conversion must be lost
         fire <= (again && len == 4) ? f : 3'h0;
      end
      repeat (3) @(posedge clk);
   endtask : conv_run

   task automatic run(input string nm, input logic [31:0] c1, c2, c3, pr, gp, sc,
                      input int sw, ex, input bit ag, input int ps[$], input logic [3:0] es);
      int i0, i, sl;
      logic [2:0] f;
      rst;
      lf = lfsr_next(lf);
      base <= lf[6:0];
      i0 = irqs;
      sl = c3[8] ? 4 : int'(c3[7:0]);
      bus(1'b1, OFS_CTL3, c3);
      bus(1'b1, OFS_CTL2, c2);
      bus(1'b1, OFS_PRI, pr);
      bus(1'b1, OFS_GRP, gp);
      bus(1'b1, OFS_SCAN, sc);
      bus(1'b1, OFS_CTL1, c1);
      f = (c1[3:1] == 3'h1) ? 3'h1 : (c1[3:1] inside {3'h2, 3'h4}) ? 3'h2 : 3'h4;
      for (i = 0; i < sw; i++) begin
         conv_run(f, ag && i == 0);
         chk({nm, " len"}, 1, (len <= ex && len + sl >= ex));
         if (ag && i == 0) chk({nm, " drop"}, i0, irqs);
      end
      chk({nm, " irq"}, i0 + 1, irqs);
      chk({nm, " samp"}, es, s1);
      for (i = 0; i < ps.size(); i++) begin
         bus(1'b0, 8'(OFS_BUF + 4 * i), 32'h0);
         chk({nm, " buf"}, fmt(ps[i], c1), q[15:0]);
      end
      bus(1'b0, OFS_STAT, 32'h0);
      chk({nm, " ptr"}, 0, q[3:0]);
      $display("test %s done", nm);
   endtask : run

   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      test_done;
   end

   initial begin
      rst;
      bus(1'b0, OFS_CTL1, 32'h0);
      chk("ctl1 reset", 32'h1, q);
      bus(1'b0, 8'h30, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, OFS_STAT, 32'hffff);
      bus(1'b0, OFS_STAT, 32'h0);
      chk("stat ro", 32'h0, q[8:0]);
      bus(1'b1, OFS_CTL1, 32'h3);
      bus(1'b1, OFS_CTL3, 32'h40);
      bus(1'b0, OFS_STAT, 32'h0);
      chk("div err", 1, q[6]);
      conv_run(3'h1, 1'b0);
      chk("div hold", 0, len);
      bus(1'b1, OFS_CTL3, 32'h0);
      bus(1'b1, OFS_CTL1, 32'h2);
      bus(1'b0, OFS_STAT, 32'h0);
      chk("auto err", 1, q[7]);
      conv_run(3'h1, 1'b0);
      chk("auto hold", 0, len);
      bus(1'b1, OFS_CTL2, 32'h7e);
      bus(1'b0, OFS_STAT, 32'h0);
      chk("cnt err", 1, q[8]);
      $display("test errors done");
      for (int i = 1; i < 6; i++)
         run($sformatf("trig%0d", i), 1 | i << 1 | (i % 4) << 4, 0, 0, i + 3, 0, 0,
             1, 12, 0, '{i + 3}, 4'h0);
      run("bits12", 32'h73, 32'h6, 0, 5, 0, 0, 1, 14, 0, '{5}, 4'h0);
      run("sim4", 32'h3, 32'h6, 0, 32'h29, 32'h3, 0, 1, 48, 0, '{9, 3, 4, 5}, 4'h0);
      chk("neg sel", {4'h0, 5'd11, 5'd10, 5'd9, 5'd1}, {mux.neg_ref, mux.neg});
      run("seq2", 32'h3, 32'h9, 0, 9, 0, 0, 1, 24, 0, '{9, 0}, 4'h2);
      run("div3", 32'h3, 32'h8, 3, 9, 0, 0, 2, 48, 0, '{9, 9}, 4'h0);
      run("rc", 32'h3, 0, 32'h13f, 9, 0, 0, 1, 60, 0, '{9}, 4'h0);
      run("drop", 32'h3, 32'h8, 0, 6, 0, 0, 2, 12, 1, '{6, 6}, 4'h0);
      run("alternate_input_sel", 32'h3, 32'h88, 0, 32'h247, 0, 0, 2, 12, 0, '{7, 9}, 4'h0);
      run("fixed", 32'h3, 32'h8, 0, 32'h247, 0, 0, 2, 12, 0, '{7, 7}, 4'h0);
      run("scan", 32'h3, 32'h108, 0, 7, 0, 32'h24, 2, 12, 0, '{2, 5}, 4'h0);
      run("scanalt", 32'h3, 32'h198, 0, 32'h207, 0, 32'h24, 4, 12, 0,
          '{2, 8, 5, 8}, 4'h0);
      test_done;
   end
endmodule : asc_top_tb
`default_nettype wire
